// File: logic/sas_pkg.sv
package sas_pkg;

    // ------------------------------------------------------------------
    // Register addresses in I/O space (word addresses)
    // ------------------------------------------------------------------
    localparam logic [15:0] ADDR_CONTROL     = 16'h6800;
    localparam logic [15:0] ADDR_RESULT      = 16'h6801;
    localparam logic [15:0] ADDR_DIVIDER_CFG = 16'h6802;
    localparam logic [15:0] ADDR_CLOCK_GATE  = 16'h6803;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTL_TRIGGER_BIT  = 15;
    localparam int CTL_SEL_LSB      = 12;
    localparam int RES_PENDING_BIT  = 15;
    localparam int RES_CHAN_LSB     = 12;
    localparam int DIV_SH_LSB       = 8;
    localparam int DIV_CONV_LSB     = 0;
    localparam int GATE_IDLE_BIT    = 8;
    localparam int GATE_PRESCALE_LSB = 0;

    // ------------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------------
    localparam int SEL_W       = 3;
    localparam int RESULT_W    = 10;
    localparam int NUM_INPUTS  = 4;
    localparam int CONV_DIV_W  = 4;
    localparam int SH_DIV_W    = 8;
    localparam int PRESCALE_W  = 8;
    localparam int TICK_CNT_W  = 10;
    localparam int HALF_CNT_W  = 5;
    localparam int CONV_CLOCKS = 13;
    localparam logic [HALF_CNT_W-1:0] CONV_HALF_PERIODS =
        HALF_CNT_W'(2 * CONV_CLOCKS);

    // ------------------------------------------------------------------
    // Timing limits that software must respect
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS       = 100;
    localparam int MIN_SAMPLE_HOLD_NS  = 40000;
    localparam int MIN_SAMPLE_HOLD_CYC =
        (MIN_SAMPLE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MAX_CONV_CLK_HZ     = 2000000;

    // ------------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------------
    localparam logic [SEL_W-1:0]      RST_SEL      = 3'h7;
    localparam logic [SH_DIV_W-1:0]   RST_SH_DIV   = 8'hff;
    localparam logic [CONV_DIV_W-1:0] RST_CONV_DIV = 4'hf;
    localparam logic [PRESCALE_W-1:0] RST_PRESCALE = 8'hff;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_SAMPLE,
        PH_CONVERT
    } sas_phase_e;

endpackage : sas_pkg

// File: logic/sas_adc_seq.sv
`timescale 1ns/100ps

// Behaviour
// RULE1: Each result is a 10-bit binary value of the sampled input.
// RULE2: At most one of four analog inputs is switched to the converter.
// RULE3: ADC clock is the system clock divided by prescale plus one.
// RULE4: Conversion clock is ADC clock over twice divider plus one; max 2 MHz.
// RULE5: Sample-hold time follows from ADC clock and both dividers; min 40 us.
// RULE6: Approximation phase lasts exactly 13 conversion clock cycles.
// RULE7: Total conversion is sample-hold then approximation, nothing else.
// RULE8: Single-shot only; each conversion starts by writing trigger bit 1.
// RULE9: Software keeps selector and trigger still while a conversion runs.
// RULE10: No interrupt or DMA request; software polls the pending flag.
// RULE11: Pending flag falls from 1 to 0 when the result becomes valid.
// RULE12: The selector used is echoed into the result register.
// RULE13: Idle with the peripheral domain only when idle permit is 1.
// RULE14: Four registers decode at I/O addresses 6800 through 6803.
// RULE15: Control register is read/write, holds selector and takes trigger.
// RULE16: Trigger is bit 15, writing 0 ignored, self-clears during conversion.
// RULE17: Selector codes 0..3 pick inputs 0..3; codes 4..7 open all switches.
// RULE18: Sample-hold equals ADC clock period times 2*(conv div+1+sh div).
// RULE19: Sample-hold divider in bits 15-8, conversion divider in bits 3-0.
// RULE20: Pending sets on accepted trigger and holds through both phases.
module sas_adc_seq (
    input  wire logic                           i_clk_sys,
    input  wire logic                           i_reset,
    input  wire logic [15:0]                    i_io_addr,
    input  wire logic [15:0]                    i_io_wdata,
    input  wire logic                           i_io_wr,
    input  wire logic                           i_io_rd,
    output logic      [15:0]                    o_io_rdata,
    input  wire logic                           i_periph_idle,
    input  wire logic [sas_pkg::RESULT_W-1:0]   i_sar_data,
    output logic      [sas_pkg::NUM_INPUTS-1:0] o_switch_on,
    output logic                                o_sample_hold,
    output logic                                o_conv_clk,
    output logic                                o_sar_run,
    output logic                                o_sar_done,
    output logic                                o_adc_idle
);
    import sas_pkg::*;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [TICK_CNT_W-1:0] sh_len(
        input logic [CONV_DIV_W-1:0] cdiv,
        input logic [SH_DIV_W-1:0]   sdiv
    );
        sh_len = TICK_CNT_W'(({2'b00, sdiv} + {6'h00, cdiv} + 10'h001) << 1);
    endfunction : sh_len

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic                    trig;
    logic [SEL_W-1:0]        sel;
    logic [SH_DIV_W-1:0]     sh_div;
    logic [CONV_DIV_W-1:0]   conv_div;
    logic                    idle_permit;
    logic [PRESCALE_W-1:0]   prescale;
    logic                    pending;
    logic [RESULT_W-1:0]     res_data;
    logic [SEL_W-1:0]        res_chan;
    logic [SEL_W-1:0]        run_sel;
    logic [PRESCALE_W-1:0]   pre_cnt;
    logic [TICK_CNT_W-1:0]   tick_cnt;
    logic [CONV_DIV_W-1:0]   half_cnt;
    logic [HALF_CNT_W-1:0]   half_edges;
    sas_phase_e              phase;
    logic                    adc_tick;
    logic                    start;
    logic                    sample_end;
    logic                    conv_end;
    logic                    wr_ctl;
    logic [SEL_W-1:0]        route_sel;

    assign wr_ctl   = i_io_wr && (i_io_addr == ADDR_CONTROL);
    assign start    = trig && (phase == PH_IDLE);
    assign adc_tick = !o_adc_idle && (pre_cnt >= prescale);
    assign sample_end = adc_tick && (phase == PH_SAMPLE)        // see RULE5
                        && (tick_cnt == sh_len(conv_div, sh_div) - 10'h001);
    assign conv_end = adc_tick && (phase == PH_CONVERT)
                      && (half_cnt == conv_div)
                      && (half_edges == CONV_HALF_PERIODS - 5'h01);

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    // A trigger written while busy is dropped, so a stray write cannot
    // queue a second conversion behind the running one.
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            trig <= 1'b0;
            sel  <= RST_SEL;
        end else begin
            if (wr_ctl) begin                                   // see RULE15
                sel <= i_io_wdata[CTL_SEL_LSB +: SEL_W];
            end
            if (start) begin
                trig <= 1'b0;                                   // see RULE16
            end else if (wr_ctl && i_io_wdata[CTL_TRIGGER_BIT]
                         && !pending) begin
                trig <= 1'b1;                                   // see RULE8
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            sh_div      <= RST_SH_DIV;
            conv_div    <= RST_CONV_DIV;
            idle_permit <= 1'b0;
            prescale    <= RST_PRESCALE;
        end else if (i_io_wr) begin
            if (i_io_addr == ADDR_DIVIDER_CFG) begin            // see RULE19
                sh_div   <= i_io_wdata[DIV_SH_LSB +: SH_DIV_W];
                conv_div <= i_io_wdata[DIV_CONV_LSB +: CONV_DIV_W];
            end
            if (i_io_addr == ADDR_CLOCK_GATE) begin
                idle_permit <= i_io_wdata[GATE_IDLE_BIT];
                prescale    <= i_io_wdata[GATE_PRESCALE_LSB +: PRESCALE_W];
            end
        end
    end

    // ------------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------------
    // Unmapped addresses and reserved bits read as zero.
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_io_rdata <= 16'h0000;
        end else if (i_io_rd) begin                             // see RULE14
            unique case (i_io_addr)
                ADDR_CONTROL:
                    o_io_rdata <= {trig, sel, 12'h000};
                ADDR_RESULT:                                    // see RULE10
                    o_io_rdata <= {pending, res_chan, 2'b00, res_data};
                ADDR_DIVIDER_CFG:
                    o_io_rdata <= {sh_div, 4'h0, conv_div};
                ADDR_CLOCK_GATE:
                    o_io_rdata <= {7'h00, idle_permit, prescale};
                default:
                    o_io_rdata <= 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // ADC clock prescaler and idle
    // ------------------------------------------------------------------
    // The ADC clock is a one-cycle enable rather than a real clock, which
    // keeps the whole block on one domain; idle simply freezes it.
    assign o_adc_idle = i_periph_idle && idle_permit;           // see RULE13

    // The divider restarts on start so that sampling begins on an ADC
    // clock boundary; a free-running divider would cut up to one ADC
    // period off the sample-hold interval.
    always_ff @(posedge i_clk_sys) begin
        if (i_reset || start) begin
            pre_cnt <= '0;
        end else if (!o_adc_idle) begin
            if (pre_cnt >= prescale) begin                      // see RULE3
                pre_cnt <= '0;
            end else begin
                pre_cnt <= pre_cnt + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // Conversion sequence
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            phase <= PH_IDLE;
        end else begin
            unique case (phase)                                 // see RULE7
                PH_IDLE:    if (start) phase <= PH_SAMPLE;
                PH_SAMPLE:  if (sample_end) phase <= PH_CONVERT;
                PH_CONVERT: if (conv_end) phase <= PH_IDLE;
                default:    phase <= PH_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset || start || sample_end) begin
            tick_cnt <= '0;
        end else if (adc_tick && phase == PH_SAMPLE) begin      // see RULE18
            tick_cnt <= tick_cnt + 10'h001;
        end
    end

    // The conversion clock toggles every conv_div+1 ADC ticks, giving a
    // period of 2*(conv_div+1) ticks; 26 half periods make 13 cycles.
    always_ff @(posedge i_clk_sys) begin
        if (i_reset || sample_end) begin
            half_cnt   <= '0;
            half_edges <= '0;
            o_conv_clk <= 1'b0;
        end else if (adc_tick && phase == PH_CONVERT) begin
            if (half_cnt == conv_div) begin                     // see RULE4
                half_cnt   <= '0;
                half_edges <= half_edges + 5'h01;               // see RULE6
                o_conv_clk <= !o_conv_clk;
            end else begin
                half_cnt <= half_cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            pending <= 1'b0;
            run_sel <= RST_SEL;
        end else if (start) begin
            pending <= 1'b1;                                    // see RULE20
            run_sel <= sel;
        end else if (conv_end) begin
            pending <= 1'b0;                                    // see RULE11
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            res_data   <= '0;
            res_chan   <= '0;
            o_sar_done <= 1'b0;
        end else begin
            o_sar_done <= conv_end;
            if (conv_end) begin
                res_data <= i_sar_data;                         // see RULE1
                res_chan <= run_sel;                            // see RULE12
            end
        end
    end

    // ------------------------------------------------------------------
    // Analog core controls
    // ------------------------------------------------------------------
    // While busy the switches follow the latched selector, so a careless
    // write cannot move the input mid-sample.
    assign route_sel = pending ? run_sel : sel;

    always_comb begin
        o_switch_on = '0;
        if (!route_sel[SEL_W-1]) begin                          // see RULE17
            o_switch_on[route_sel[1:0]] = 1'b1;                 // see RULE2
        end
    end

    assign o_sample_hold = (phase == PH_SAMPLE);
    assign o_sar_run     = (phase == PH_CONVERT);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [PRESCALE_W-1:0] gap_cnt;
    logic [TICK_CNT_W-1:0] conv_ticks;

    always_ff @(posedge i_clk_sys) begin
        if (i_reset || adc_tick || start) begin
            gap_cnt <= '0;
        end else if (!o_adc_idle) begin
            gap_cnt <= gap_cnt + 8'h01;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset || sample_end) begin
            conv_ticks <= '0;
        end else if (adc_tick && phase == PH_CONVERT) begin
            conv_ticks <= conv_ticks + 10'h001;
        end
    end

    trig_clear_a: assert property (@(posedge i_clk_sys) // see RULE16
        disable iff (i_reset) start |=> !trig && pending)
        else $error("trigger did not clear on start");

    pend_hold_a: assert property (@(posedge i_clk_sys) // see RULE20
        disable iff (i_reset) (phase != PH_IDLE) |-> pending)
        else $error("pending low during conversion");

    result_load_a: assert property (@(posedge i_clk_sys) // see RULE11
        disable iff (i_reset)
        $fell(pending) |-> res_data == $past(i_sar_data) && o_sar_done)
        else $error("result not loaded when pending fell");

    chan_echo_a: assert property (@(posedge i_clk_sys) // see RULE12
        disable iff (i_reset)
        $fell(pending) |-> res_chan == run_sel)
        else $error("channel echo mismatch");

    switch_one_a: assert property (@(posedge i_clk_sys) // see RULE17
        disable iff (i_reset)
        $onehot0(o_switch_on) && (route_sel[2] == (o_switch_on == 4'h0)))
        else $error("input switch decode wrong");

    sample_len_a: assert property (@(posedge i_clk_sys) // see RULE18
        disable iff (i_reset)
        sample_end |-> tick_cnt + 10'h001 == sh_len(conv_div, sh_div)
        ##1 phase == PH_CONVERT)
        else $error("sample-hold length wrong");

    conv_len_a: assert property (@(posedge i_clk_sys) // see RULE6
        disable iff (i_reset)
        conv_end |-> conv_ticks + 10'h001
            == 10'(26 * ({6'h00, conv_div} + 10'h001)))
        else $error("conversion phase length wrong");

    prescale_gap_a: assert property (@(posedge i_clk_sys) // see RULE3
        disable iff (i_reset)
        adc_tick && $past(adc_tick)
        |-> prescale == 8'h00 || $changed(prescale))
        else $error("ADC clock ticks too often");

    tick_gap_a: assert property (@(posedge i_clk_sys) // see RULE3
        disable iff (i_reset)
        adc_tick && $stable(prescale) && !$past(o_adc_idle)
        |-> gap_cnt == prescale || $past(adc_tick))
        else $error("ADC clock spacing wrong");

    idle_freeze_a: assert property (@(posedge i_clk_sys) // see RULE13
        disable iff (i_reset)
        o_adc_idle && phase != PH_IDLE |=> $stable(tick_cnt)
            && $stable(half_edges))
        else $error("sequence advanced while idle");

    pend_read_a: assert property (@(posedge i_clk_sys) // see RULE10
        disable iff (i_reset)
        i_io_rd && i_io_addr == ADDR_RESULT
        |=> o_io_rdata[RES_PENDING_BIT] == $past(pending))
        else $error("pending flag not readable");

    trig_zero_a: assert property (@(posedge i_clk_sys) // see RULE16
        disable iff (i_reset)
        wr_ctl && !i_io_wdata[CTL_TRIGGER_BIT] && !trig |=> !trig)
        else $error("trigger set by a write of zero");

    conv_clk_idle_a: assert property (@(posedge i_clk_sys) // see RULE4
        disable iff (i_reset) !o_sar_run |-> !o_conv_clk)
        else $error("conversion clock high outside conversion");

endmodule : sas_adc_seq

// File: verification/sas_sar_model.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// Converter core stand-in
// ----------------------------------------------------------------------
module sas_sar_model #(
    parameter logic [9:0] BASE = 10'h2c5,
    parameter logic [9:0] STEP = 10'h0f3
) (
    input  wire logic       i_clk_sys,
    input  wire logic [3:0] i_switch_on,
    input  wire logic       i_sar_run,
    output logic      [9:0] o_sar_data
);
    logic [9:0] level;
    logic [9:0] held = 10'h155;

    // Each input carries its own level; with every switch open it reads 0.
    always_comb begin
        level = 10'h000;
        for (int k = 0; k < 4; k++) begin
            if (i_switch_on[k]) begin
                level = BASE ^ 10'(STEP * k);
            end
        end
    end

    // Outside the approximation phase the output is not valid, so it
    // changes every cycle rather than holding a value that might pass.
    always_ff @(posedge i_clk_sys) begin
        held <= i_sar_run ? level : ~held;
    end

    assign o_sar_data = held;
endmodule : sas_sar_model

// File: verification/tb.sv
`timescale 1ns/100ps

module tb;
    import sas_pkg::*;
    logic        i_clk_sys, i_reset, i_io_wr, i_io_rd, i_periph_idle;
    logic [15:0] i_io_addr, i_io_wdata, o_io_rdata, rd_val;
    logic [9:0]  i_sar_data;
    logic [3:0]  o_switch_on, sw_seen;
    logic        o_sample_hold, o_conv_clk, o_sar_run, o_sar_done;
    logic        o_adc_idle, counting, prev_clk;
    int          bad_count, checks, cycles, sh_n, run_n, rises;

    sas_adc_seq dut_u (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
        .i_io_addr(i_io_addr), .i_io_wdata(i_io_wdata), .i_io_wr(i_io_wr),
        .i_io_rd(i_io_rd), .o_io_rdata(o_io_rdata),
        .i_periph_idle(i_periph_idle), .i_sar_data(i_sar_data),
        .o_switch_on(o_switch_on), .o_sample_hold(o_sample_hold),
        .o_conv_clk(o_conv_clk), .o_sar_run(o_sar_run),
        .o_sar_done(o_sar_done), .o_adc_idle(o_adc_idle));

    sas_sar_model model_u (.i_clk_sys(i_clk_sys), .i_switch_on(o_switch_on),
        .i_sar_run(o_sar_run), .o_sar_data(i_sar_data));

    initial begin
        i_clk_sys = 1'b0;
        forever #50 i_clk_sys = ~i_clk_sys;
    end

    // ------------------------------------------------------------------
    // Phase monitor, kept apart so register reads can overlap a run
    // ------------------------------------------------------------------
    always @(negedge i_clk_sys) begin
        if (counting) begin
            if (o_sample_hold === 1'b1) begin
                sh_n++;
                sw_seen = o_switch_on;
            end
            if (o_sar_run === 1'b1) run_n++;
            if (o_conv_clk === 1'b1 && prev_clk === 1'b0) rises++;
            prev_clk = o_conv_clk;
        end
    end

    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    task automatic chk(input string name, input logic [15:0] got, exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, d);
        @(negedge i_clk_sys);
        i_io_addr = a;
        i_io_wdata = d;
        i_io_wr = 1'b1;
        @(negedge i_clk_sys);
        i_io_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a);
        @(negedge i_clk_sys);
        i_io_addr = a;
        i_io_rd = 1'b1;
        @(negedge i_clk_sys);
        i_io_rd = 1'b0;
        rd_val = o_io_rdata;
    endtask : rd

    task automatic test_reset();
        rd(16'h6800);
        chk("control", rd_val, 16'h7000);
        rd(16'h6801);
        chk("pending", rd_val & 16'h8000, 16'h0000);
        rd(16'h6802);
        chk("divider", rd_val, 16'hff0f);
        rd(16'h6803);
        chk("gate", rd_val, 16'h00ff);
        rd(16'h6804);
        chk("unmapped", rd_val, 16'h0000);
        chk("switches", {12'h0, o_switch_on}, 16'h0000);
        $display("test reset done");
    endtask : test_reset

    task automatic test_regs();
        wr(16'h6802, 16'hfff5);
        rd(16'h6802);
        chk("divider", rd_val, 16'hff05);
        wr(16'h6803, 16'hffa5);
        rd(16'h6803);
        chk("gate", rd_val, 16'h01a5);
        wr(16'h6800, 16'h2fff);
        rd(16'h6800);
        chk("control", rd_val, 16'h2000);
        chk("no start", {15'h0, o_sample_hold}, 16'h0000);
        $display("test registers done");
    endtask : test_regs

    task automatic test_idle();
        for (int p = 0; p < 2; p++) begin
            for (int q = 0; q < 2; q++) begin
                wr(16'h6803, {7'h0, 1'(p), 8'h00});
                i_periph_idle = 1'(q);
                @(negedge i_clk_sys);
                chk("idle", {15'h0, o_adc_idle}, 16'(p & q));
            end
        end
        i_periph_idle = 1'b0;
        $display("test idle done");
    endtask : test_idle

    // Idle with permit set must stall a run, then let it finish intact.
    task automatic test_pause();
        int n;
        wr(16'h6803, 16'h0100);
        wr(16'h6802, 16'h0000);
        {sh_n, run_n, n} = '0;
        counting = 1'b1;
        wr(16'h6800, 16'h8000);
        i_periph_idle = 1'b1;
        repeat (10) @(negedge i_clk_sys);
        chk("stalled", {15'h0, o_sample_hold}, 16'h0001);
        i_periph_idle = 1'b0;
        while (o_sar_done !== 1'b1 && n < 2000) begin
            @(negedge i_clk_sys);
            n++;
        end
        counting = 1'b0;
        chk("stall length", 16'(sh_n), 16'd11);
        chk("approx", 16'(run_n), 16'd26);
        rd(16'h6801);
        chk("result", rd_val, 16'h02c5);
        $display("test pause done");
    endtask : test_pause

    // One single-shot conversion; phase lengths are counted in CPU cycles.
    task automatic run_conv(input int sel, ps, cd, sd);
        int n;
        logic [9:0] data;
        data = sel < 4 ? 10'h2c5 ^ 10'(10'h0f3 * sel) : 10'h000;
        wr(16'h6803, 16'(ps));
        wr(16'h6802, {8'(sd), 4'h0, 4'(cd)});
        {sh_n, run_n, rises, n} = '0;
        prev_clk = 1'b0;
        counting = 1'b1;
        wr(16'h6800, 16'h8000 | 16'(sel << 12));
        rd(16'h6801);
        chk("busy", rd_val & 16'h8000, 16'h8000);
        rd(16'h6800);
        chk("trig", rd_val, 16'(sel << 12));
        while (o_sar_done !== 1'b1 && n < 2000) begin
            @(negedge i_clk_sys);
            n++;
        end
        counting = 1'b0;
        chk("done", 16'(n < 2000), 16'h0001);
        chk("sample", 16'(sh_n), 16'(2*(cd+1+sd)*(ps+1)));
        chk("approx", 16'(run_n), 16'(26 * (cd + 1) * (ps + 1)));
        chk("ticks", 16'(rises), 16'd13);
        chk("switch", {12'h0, sw_seen}, 16'(sel<4 ? 1<<sel : 0));
        rd(16'h6801);
        chk("result", rd_val, {1'b0, 3'(sel), 2'b00, data});
        $display("test conversion %0d done", sel);
    endtask : run_conv

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        {i_reset, i_io_wr, i_io_rd, i_periph_idle, counting} = 5'h10;
        i_io_addr = 16'h0000;
        i_io_wdata = 16'h0000;
        repeat (6) @(negedge i_clk_sys);
        i_reset = 1'b0;
        test_reset();
        test_regs();
        test_idle();
        test_pause();
        run_conv(0, 0, 0, 2);
        run_conv(1, 1, 1, 1);
        run_conv(2, 2, 0, 0);
        run_conv(3, 0, 2, 3);
        run_conv(5, 0, 0, 0);
        tally_and_finish();
    end
endmodule : tb
